/* File: pgd_map.svh */
`ifndef PGD_MAP_SVH
`define PGD_MAP_SVH

// packet layout
`define PGD_PKT_BITS      32
`define PGD_ID_MSB        31
`define PGD_ID_LSB        24
`define PGD_INFO_BITS     24
`define PGD_ID_CHECKSUM   8'h00
`define PGD_ID_CONTROL    8'h02
`define PGD_ON_BIT        0
`define PGD_LAST_BIT      6'h1F
`define PGD_BIT_DONE      6'h20

// clock and serial timing
`define PGD_CLK_KHZ       100000
`define PGD_SCK_HALF      50
`define PGD_FIFO_DEPTH    16

// powerdown spacing, times in milliseconds
`define PGD_PD_GAP_MS     2
`define PGD_PD_MAX_MS     95
`define PGD_PD_GAP_CYC    (`PGD_PD_GAP_MS * `PGD_CLK_KHZ)
`define PGD_PD_MAX_CYC    (64'(`PGD_PD_MAX_MS) * 64'(`PGD_CLK_KHZ))
`define PGD_PD_LAST_STEP  2'h2
`define PGD_PD_ON_STEP    2'h1

`endif

/* File: pgd_pkg.sv */
`default_nettype none
package pgd_pkg;
  // link sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SEL   = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DESEL = 4'b1000
  } pgd_state_t;

  // origin of the packet being shifted
  typedef enum logic [1:0] {
    SRC_FIFO = 2'h0,
    SRC_PD   = 2'h1,
    SRC_NULL = 2'h2
  } pgd_src_t;
endpackage : pgd_pkg
`default_nettype wire

/* File: pgd_host.sv */
// Operation
// (R1) every transfer is exactly 32 bits
// (R2) 8-bit id on top, 24 info bits
// (R3) full duplex, both directions carry packets
// (R4) host selects, waits ready, shifts, deselects
// (R5) fresh select falling edge per host packet
// (R6) decoder returns status on host packets
// (R7) ready low makes host clock one exchange
// (R8) select may stay low between decoder packets
// (R9) host sends null checksum when idle-reading
// (R10) decoder drives ready only when prepared
// (R11) decoder data output is three-state; the model drives o_miso at all times, inverting it on deselect
// (R12) host supplies clock, drives master-out line
// (R13) decoder must be asynchronous before switch-off
// (R14) control packets off, on, off in order
// (R15) spacing measured last edge to last edge
// (R16) at least 2 ms between powerdown steps
// (R17) on-to-off step within warm-up and 95 ms
// (R18) warm-up is sum of selected settings
// (R19) decoder outputs 38.4 kHz divided clock
// (R20) decoder keeps a one-minute timer
// (R21) decoder has five receiver control outputs
// (R22) decoder resets while reset pin low
// (R23) most significant bit travels first
// (R24) outbound blocked until matching checksum
// (R25) checksum packet id is zero
// (R26) decoder ignores clock while deselected
// (R27) partial packet discarded on early deselect
`include "pgd_map.svh"
`default_nettype none

// packet queue between user and link
module pgd_fifo
  import pgd_pkg::*;
#(
  parameter int WIDTH = `PGD_PKT_BITS,
  parameter int DEPTH = `PGD_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // honest full and empty from the fill count
  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and storage next values
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = i_in_data;
      wr_nxt        = wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_r <= '{default: '0};
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : pgd_fifo

// host-side master of the decoder packet port
module pgd_host
  import pgd_pkg::*;
#(
  parameter int          SCK_HALF   = `PGD_SCK_HALF,
  parameter int          FIFO_DEPTH = `PGD_FIFO_DEPTH,
  parameter int unsigned PD_GAP_CYC = `PGD_PD_GAP_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tx_valid,
  input  wire logic [31:0] i_tx_data,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic      [31:0] o_rx_data,
  input  wire logic        i_pd_req,
  output logic             o_pd_busy,
  output logic             o_pd_done,
  output logic             o_busy,
  output logic             o_ss_n,
  output logic             o_sck,
  output logic             o_mosi,
  input  wire logic        i_miso,
  input  wire logic        i_ready_n
);
  if (SCK_HALF < 1 || SCK_HALF > 65535) begin : g_bad_half
    $error("serial half period out of range");
  end
  if (PD_GAP_CYC < 1 || 64'(PD_GAP_CYC) >= `PGD_PD_MAX_CYC) begin : g_bad_gap
    $error("powerdown gap must be below the 95 ms ceiling"); // R17
  end

  pgd_state_t  state_r, state_nxt;
  pgd_src_t    src_r, src_nxt;
  logic        sck_r, sck_nxt, ss_n_r, ss_n_nxt;
  logic [15:0] div_r, div_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic [31:0] tx_r, tx_nxt, rx_r, rx_nxt, rxd_r, rxd_nxt;
  logic        rxv_r, rxv_nxt, pkt_end, fifo_pop, half_tick;
  logic        miso_m_r, miso_s_r, rdy_m_r, rdy_s_r;
  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic [1:0]  pd_step_r, pd_step_nxt;
  logic        pd_busy_r, pd_busy_nxt, pd_done_r, pd_done_nxt;
  logic [31:0] pd_wait_r, pd_wait_nxt;
  logic        pd_want;
  logic [23:0] pd_info;

  pgd_fifo #(
    .WIDTH (`PGD_PKT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) pgd_fifo_i (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_data),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  // two-stage synchronisers for the decoder pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      rdy_m_r  <= 1'b1;
      rdy_s_r  <= 1'b1;
    end else begin
      miso_m_r <= i_miso;
      miso_s_r <= miso_m_r;
      rdy_m_r  <= i_ready_n;
      rdy_s_r  <= rdy_m_r;
    end
  end

  assign half_tick = (div_r == 16'(SCK_HALF - 1));
  assign pd_want   = pd_busy_r && (pd_wait_r == '0) && (state_r == ST_IDLE);
  assign pd_info   = 24'(pd_step_r == `PGD_PD_ON_STEP) << `PGD_ON_BIT; // R14

  // link sequencer next values
  always_comb begin
    state_nxt = state_r;
    src_nxt   = src_r;
    sck_nxt   = sck_r;
    ss_n_nxt  = ss_n_r;
    div_nxt   = div_r;
    bit_nxt   = bit_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    rxd_nxt   = rxd_r;
    rxv_nxt   = 1'b0;
    pkt_end   = 1'b0;
    fifo_pop  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        div_nxt = '0;
        bit_nxt = '0;
        sck_nxt = 1'b0;
        if (pd_want) begin
          tx_nxt    = {`PGD_ID_CONTROL, pd_info}; // R2 R13
          src_nxt   = SRC_PD;
          ss_n_nxt  = 1'b0; // R4 R5
          state_nxt = ST_SEL;
        end else if (fifo_valid && !pd_busy_r) begin
          tx_nxt    = fifo_data;
          fifo_pop  = 1'b1;
          src_nxt   = SRC_FIFO;
          ss_n_nxt  = 1'b0; // R4 R5
          state_nxt = ST_SEL;
        end else if (!rdy_s_r) begin
          tx_nxt    = {`PGD_ID_CHECKSUM, `PGD_INFO_BITS'(0)}; // R7 R9 R25
          src_nxt   = SRC_NULL;
          ss_n_nxt  = 1'b0;
          state_nxt = ST_SEL;
        end
      end
      ST_SEL: begin
        // hold select low until the decoder signals ready
        if (!rdy_s_r) begin
          state_nxt = ST_SHIFT; // R4 R10
        end
      end
      ST_SHIFT: begin
        if (half_tick) begin
          div_nxt = '0;
          sck_nxt = !sck_r; // R12
          if (!sck_r) begin
            rx_nxt  = {rx_r[30:0], miso_s_r}; // R3 R23
            bit_nxt = bit_r + 1'b1;
            if (bit_r == `PGD_LAST_BIT) begin
              pkt_end = 1'b1; // R1 R15
              rxd_nxt = {rx_r[30:0], miso_s_r};
              rxv_nxt = 1'b1;
            end
          end else if (bit_r == `PGD_BIT_DONE) begin
            ss_n_nxt  = 1'b1; // R4 R8
            state_nxt = ST_DESEL;
          end else begin
            tx_nxt = {tx_r[30:0], 1'b0}; // R23
          end
        end else begin
          div_nxt = div_r + 1'b1;
        end
      end
      ST_DESEL: begin
        // select high for a half period so each packet sees a new edge
        if (half_tick) begin
          div_nxt   = '0;
          state_nxt = ST_IDLE; // R5 R26
        end else begin
          div_nxt = div_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ss_n_nxt  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      src_r   <= SRC_NULL;
      sck_r   <= 1'b0;
      ss_n_r  <= 1'b1;
      div_r   <= '0;
      bit_r   <= '0;
      tx_r    <= '0;
      rx_r    <= '0;
      rxd_r   <= '0;
      rxv_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      src_r   <= src_nxt;
      sck_r   <= sck_nxt;
      ss_n_r  <= ss_n_nxt;
      div_r   <= div_nxt;
      bit_r   <= bit_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      rxd_r   <= rxd_nxt;
      rxv_r   <= rxv_nxt;
    end
  end

  // powerdown sequencer: off, on, off with spacing
  always_comb begin
    pd_busy_nxt = pd_busy_r;
    pd_step_nxt = pd_step_r;
    pd_wait_nxt = pd_wait_r;
    pd_done_nxt = 1'b0;
    if (pd_wait_r != '0) begin
      pd_wait_nxt = pd_wait_r - 1'b1;
    end
    if (i_pd_req && !pd_busy_r) begin
      pd_busy_nxt = 1'b1;
      pd_step_nxt = '0;
      pd_wait_nxt = '0;
    end else if (pkt_end && src_r == SRC_PD) begin
      pd_wait_nxt = PD_GAP_CYC; // R15 R16
      if (pd_step_r == `PGD_PD_LAST_STEP) begin
        pd_busy_nxt = 1'b0;
        pd_done_nxt = 1'b1;
      end else begin
        pd_step_nxt = pd_step_r + 1'b1; // R14 R17
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_busy_r <= 1'b0;
      pd_step_r <= '0;
      pd_wait_r <= '0;
      pd_done_r <= 1'b0;
    end else begin
      pd_busy_r <= pd_busy_nxt;
      pd_step_r <= pd_step_nxt;
      pd_wait_r <= pd_wait_nxt;
      pd_done_r <= pd_done_nxt;
    end
  end

  // pin and user outputs from flops, except o_busy decoded from state_r and o_tx_ready decoded from the fifo count
  assign o_ss_n     = ss_n_r;
  assign o_sck      = sck_r;
  assign o_mosi     = tx_r[`PGD_ID_MSB]; // R23
  assign o_rx_valid = rxv_r;
  assign o_rx_data  = rxd_r;
  assign o_pd_busy  = pd_busy_r;
  assign o_pd_done  = pd_done_r;
  assign o_busy     = (state_r != ST_IDLE);
endmodule : pgd_host
`default_nettype wire

/* File: pgd_host_asserts.sv */
`default_nettype none
// link and powerdown checks at the host controller pins
module pgd_host_asserts #(
  parameter int unsigned PD_GAP_CYC = 200
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pd_req,
  input wire logic o_pd_busy,
  input wire logic o_pd_done,
  input wire logic o_rx_valid,
  input wire logic o_ss_n,
  input wire logic o_sck,
  input wire logic o_mosi,
  input wire logic i_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  rise_r;
  logic [1:0]  step_r;
  logic [31:0] gap_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // rises per selection, packets per powerdown, cycles since last packet
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_r <= 6'h00;
      step_r <= 2'h0;
      gap_r  <= 32'h0;
    end else begin
      if ($fell(o_ss_n)) rise_r <= 6'h00;
      else if ($rose(o_sck)) rise_r <= rise_r + 6'h01;
      if ($rose(o_pd_busy)) step_r <= 2'h0;
      else if ($rose(o_sck) && rise_r == 6'h1F) step_r <= step_r + 2'h1;
      if ($rose(o_sck) && rise_r == 6'h1F) gap_r <= 32'h0;
      else if (gap_r != 32'hFFFFFFFF) gap_r <= gap_r + 32'h1;
    end
  end

  a_sck_idle_low: assert property (o_ss_n |-> !o_sck)
    else $error("serial clock moves while deselected");
  a_pkt_whole: assert property ($rose(o_ss_n) |-> rise_r == 6'h20)
    else $error("packet not 32 clocks long");
  a_wait_ready: assert property
    (($rose(o_sck) && rise_r == 6'h00) |-> !$past(i_ready_n, 3))
    else $error("shift began before ready");
  a_mosi_hold: assert property ($rose(o_sck) |-> $stable(o_mosi))
    else $error("data changed at sampling edge");
  a_rx_follows: assert property
    (($rose(o_sck) && rise_r == 6'h1F) |-> ##[0:2] o_rx_valid)
    else $error("no received packet after last clock");
  a_ss_fresh: assert property ($rose(o_ss_n) |=> o_ss_n [*2])
    else $error("select high too briefly");
  a_pd_gap: assert property
    (($rose(o_sck) && rise_r == 6'h1F && (o_pd_busy || o_pd_done) &&
      step_r != 2'h0)
     |-> gap_r + 32'h1 >= PD_GAP_CYC)
    else $error("powerdown steps too close");
  a_pd_three: assert property ($fell(o_pd_busy) |=> step_r == 2'h3)
    else $error("powerdown not three packets");
  a_pd_by_req: assert property ($rose(o_pd_busy) |-> $past(i_pd_req))
    else $error("powerdown started unrequested");

  c_pd_done: cover property (o_pd_done);
  c_rx: cover property (o_rx_valid);
  c_desel: cover property ($rose(o_ss_n));
endmodule : pgd_host_asserts

bind pgd_host pgd_host_asserts #(.PD_GAP_CYC(PD_GAP_CYC)) pgd_host_asserts_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pd_req(i_pd_req),
  .o_pd_busy(o_pd_busy), .o_pd_done(o_pd_done), .o_rx_valid(o_rx_valid),
  .o_ss_n(o_ss_n), .o_sck(o_sck), .o_mosi(o_mosi), .i_ready_n(i_ready_n));
`default_nettype wire

/* File: pgd_dec_model.sv */
`default_nettype none
// behavioural decoder at the far end of the packet port
module pgd_dec_model #(
  parameter int          RDY_NS      = 400,
  parameter realtime     OSC_HALF_NS = 6510.4,
  parameter int          OSC_PER_MIN = 4608000,
  parameter logic [23:0] PART_INFO   = 24'h5A3C96 // arbitrary
) (
  input  wire logic        i_rst_n,
  input  wire logic        i_ss_n,
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_ready_n,
  input  wire logic        i_push,
  input  wire logic [31:0] i_push_data,
  output logic      [31:0] o_rx_pkt,
  output int               o_n_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh_in, sh_out, queued;
  logic [23:0] ck;
  logic [5:0]  nbit;
  logic        en, pend, sel_rdy;
  logic        osc, div_clk;
  logic [4:0]  rx_ctl;
  int          osc_n, minutes, warm_sum;

  // oscillator halved into the output clock, minute tick kept
  initial begin
    osc = 1'b0;
    div_clk = 1'b0;
    osc_n = 0;
    minutes = 0;
    rx_ctl = 'z;
    forever begin
      #(OSC_HALF_NS) osc = ~osc;
      if (osc) begin
        div_clk = ~div_clk;
        osc_n = (osc_n == OSC_PER_MIN - 1) ? 0 : osc_n + 1;
        if (osc_n == 0) minutes++;
      end
    end
  end

  // ready only while prepared to shift or holding a packet
  assign o_ready_n = !(pend || (sel_rdy && nbit < 6'h20));

  // reset: output blocked, checksum seeded
  always @(negedge i_rst_n) begin
    en = 1'b0;
    pend = 1'b0;
    sel_rdy = 1'b0;
    nbit = 6'h20;
    ck = PART_INFO;
    warm_sum = 0;
    o_n_rx = 0;
    o_miso = 1'b0;
  end

  // each select fall starts a packet, partial ones dropped
  always @(negedge i_ss_n) begin
    nbit = 6'h00;
    sel_rdy = 1'b0;
    if (pend && en) sh_out = queued;
    else if (en) sh_out = 32'h7F000000;
    else sh_out = {8'hFF, PART_INFO};
    o_miso = sh_out[31];
    #(RDY_NS);
    sel_rdy = !i_ss_n;
  end

  // capture msb first, clocks ignored while deselected
  always @(posedge i_sck) begin
    if (!i_ss_n && nbit < 6'h20) begin
      sh_in = {sh_in[30:0], i_mosi};
      nbit = nbit + 6'h01;
      if (nbit == 6'h20) take_pkt();
    end
  end

  // next reply bit after falling edge
  always @(negedge i_sck) begin
    if (!i_ss_n && nbit < 6'h20) begin
      sh_out = {sh_out[30:0], 1'b0};
      o_miso = sh_out[31];
    end
  end

  // released line shows the inverse of its last bit
  always @(posedge i_ss_n) begin
    sel_rdy = 1'b0;
    o_miso = !o_miso;
  end

  // queue one decoder packet
  always @(posedge i_push) begin
    queued = i_push_data;
    pend = 1'b1;
  end

  // checksum gating of outbound data
  task automatic take_pkt();
    o_rx_pkt = sh_in;
    o_n_rx = o_n_rx + 1;
    pend = pend && !en;
    if (sh_in[31:24] >= 8'h11 && sh_in[31:24] <= 8'h13)
      warm_sum = warm_sum + int'(sh_in[23:0]);
    if (sh_in[31:24] == 8'h00) begin
      if (sh_in[23:0] == ck) en = 1'b1;
    end else if (sh_in[31:26] != 6'h07) begin
      ck = ck ^ sh_in[23:0];
      en = 1'b0;
    end
  endtask : take_pkt
endmodule : pgd_dec_model
`default_nettype wire

/* File: tb_pgd_host.sv */
`default_nettype none
module tb_pgd_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] PART = 24'h5A3C96; // arbitrary
  logic        i_clk, i_rst_n, i_tx_valid, o_tx_ready, o_rx_valid;
  logic        i_pd_req, o_pd_busy, o_pd_done, o_busy, o_ss_n, o_sck;
  logic        o_mosi, miso, ready_n, push;
  logic [31:0] i_tx_data, o_rx_data, push_data, m_pkt;
  logic [31:0] log_pkt [0:63];
  realtime     log_t [0:63];
  int          m_n, n_sel, n_mismatch, checked, cyc, n_rxv;

  pgd_host #(.SCK_HALF(4), .FIFO_DEPTH(16), .PD_GAP_CYC(200)) pgd_host_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_valid(i_tx_valid),
    .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .i_pd_req(i_pd_req), .o_pd_busy(o_pd_busy),
    .o_pd_done(o_pd_done), .o_busy(o_busy), .o_ss_n(o_ss_n), .o_sck(o_sck),
    .o_mosi(o_mosi), .i_miso(miso), .i_ready_n(ready_n));
  pgd_dec_model pgd_dec_model_i (
    .i_rst_n(i_rst_n), .i_ss_n(o_ss_n), .i_sck(o_sck), .i_mosi(o_mosi),
    .o_miso(miso), .o_ready_n(ready_n), .i_push(push),
    .i_push_data(push_data), .o_rx_pkt(m_pkt), .o_n_rx(m_n));

  // clock, hang limit, packet log and select count
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(m_n) begin
    log_pkt[m_n[5:0]] = m_pkt;
    log_t[m_n[5:0]] = $realtime;
  end
  always @(negedge o_ss_n) n_sel++;
  always @(negedge i_clk) if (o_rx_valid === 1'b1) n_rxv++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic send(input logic [31:0] d);
    i_tx_valid = 1'b1;
    i_tx_data = d;
    @(negedge i_clk);
    i_tx_valid = 1'b0;
  endtask : send

  task automatic wait_rx(input int n);
    for (int i = 0; i < 9000 && !(m_n == n && o_busy === 1'b0); i++)
      @(negedge i_clk);
  endtask : wait_rx

  // host packets arrive whole; replies follow checksum gating
  task automatic t_host_write();
    int b;
    b = m_n;
    send(32'h0F123456);
    wait_rx(b + 1);
    check(log_pkt[b + 1], 32'h0F123456);
    check(o_rx_data, {8'hFF, PART});
    send({8'h00, PART ^ 24'h123456});
    wait_rx(b + 2);
    check(o_rx_data, {8'hFF, PART});
    send(32'h00000000);
    wait_rx(b + 3);
    check(o_rx_data, 32'h7F000000);
  endtask : t_host_write

  // decoder-initiated read answered by a null checksum
  task automatic t_dec_read();
    int b;
    b = m_n;
    push_data = 32'h01ABCDEF;
    push = 1'b1;
    @(negedge i_clk);
    push = 1'b0;
    wait_rx(b + 1);
    check(o_rx_data, 32'h01ABCDEF);
    check(log_pkt[b + 1], 32'h00000000);
  endtask : t_dec_read

  // fill queue until refused, slow far end drains it
  task automatic t_fill();
    int b, s, acc, v;
    b = m_n;
    s = n_sel;
    v = n_rxv;
    acc = 0;
    i_tx_valid = 1'b1;
    while (o_tx_ready === 1'b1 && acc < 40) begin
      i_tx_data = {8'h1C, 24'(acc)};
      @(negedge i_clk);
      acc++;
    end
    @(negedge i_clk);
    i_tx_valid = 1'b0;
    check(32'(acc), 32'h11);
    wait_rx(b + 17);
    for (int i = 0; i < 17; i++)
      check(log_pkt[b + 1 + i], {8'h1C, 24'(i)});
    check(32'(n_sel - s), 32'h11);
    check(32'(n_rxv - v), 32'h11);
  endtask : t_fill

  // powerdown off, on, off with spacing; queued word held back
  task automatic t_pdown();
    int b;
    realtime g1, g2;
    b = m_n;
    i_pd_req = 1'b1;
    @(negedge i_clk);
    i_pd_req = 1'b0;
    check(32'(o_pd_busy), 32'h1);
    send(32'h0F000001);
    for (int i = 0; i < 9000 && o_pd_done !== 1'b1; i++)
      @(negedge i_clk);
    check(32'({o_pd_busy, o_pd_done}), 32'h1);
    check(log_pkt[b + 1], 32'h02000000);
    check(log_pkt[b + 2], 32'h02000001);
    check(log_pkt[b + 3], 32'h02000000);
    g1 = log_t[b + 2] - log_t[b + 1];
    g2 = log_t[b + 3] - log_t[b + 2];
    check(32'(g1 >= 2000.0 && g2 >= 2000.0), 32'h1);
    check(32'(g2 <= 95.0e6), 32'h1);
    wait_rx(b + 4);
    check(log_pkt[b + 4], 32'h0F000001);
  endtask : t_pdown

  // reset, then the scenarios in turn
  initial begin
    i_rst_n = 1'b1;
    i_tx_valid = 1'b0;
    i_tx_data = 32'h0;
    i_pd_req = 1'b0;
    push = 1'b0;
    push_data = 32'h0;
    #1 i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    check(32'({o_ss_n, o_sck, o_busy, o_tx_ready}), 32'h9);
    t_host_write();
    t_dec_read();
    t_fill();
    t_pdown();
    tally_and_finish();
  end
endmodule : tb_pgd_host
`default_nettype wire
